// File: design/rsc_map.svh
/*
  Register offsets, field positions, reset values and timing counts of the reset source
  controller. Included by the design files; holds definitions only.
*/
`ifndef RSC_MAP_SVH
`define RSC_MAP_SVH

`define RSC_OFF_THRESH 8'h00
`define RSC_OFF_SYSCTL 8'h04
`define RSC_OFF_RSTST 8'h08
`define RSC_OFF_IRQST 8'h0C
`define RSC_OFF_IRQMSK 8'h10

`define RSC_THR_RESET 8'h55
`define RSC_THR_OK0 8'h55
`define RSC_THR_OK1 8'h33
`define RSC_THR_OK2 8'hAA
`define RSC_WE_OK0 5'h15
`define RSC_WE_OK1 5'h0A

`define RSC_BIT_WDSW 0
`define RSC_BIT_THR 1
`define RSC_BIT_BO 2
`define RSC_BIT_WDT 3
`define RSC_BIT_TO 0
`define RSC_BIT_PDF 1

`define RSC_CLK_NS 8
`define RSC_BO_QUAL_NS 120000
`define RSC_BO_QUAL_CYC ((`RSC_BO_QUAL_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS)
`define RSC_SETTLE_FAST_CYC 16
`define RSC_SETTLE_SLOW_TICKS 2
`define RSC_DBN_TICKS 2

`endif

// File: design/rsc_pkg.sv
/*
  Types shared by the reset source controller files.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package rsc_pkg;
  typedef enum logic [1:0] {
    RSC_ST_RUN = 2'b01,
    RSC_ST_SETTLE = 2'b10
  } rsc_state_e;
  typedef logic [3:0] rsc_irq_t;
endpackage : rsc_pkg
`default_nettype wire

// File: design/rsc_dbn_if.sv
/*
  Carrier between the controller and one code debouncer.
  Assumes both ends run on the same clock.
*/
`default_nettype none
interface rsc_dbn_if;
  logic bad;
  logic tick;
  logic fire;
  modport dev (input bad, input tick, output fire);
  modport user (output bad, output tick, input fire);
endinterface : rsc_dbn_if
`default_nettype wire

// File: design/rsc_debounce.sv
/*
  Debouncer for an invalid protection code: fires a one-cycle pulse once the code has
  stayed invalid across the configured number of slow oscillator ticks.
  Assumes the tick is a one-cycle pulse synchronous to aclk.
*/
`include "rsc_map.svh"
`default_nettype none
module rsc_debounce #(
  parameter int unsigned TICKS = `RSC_DBN_TICKS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  rsc_dbn_if.dev dbn
);
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic fire_r;
  logic fire_nxt;

  // The first tick may come right after the code goes bad, so the delay is 1 to 2 tick periods.
  always_comb begin
    cnt_nxt = cnt_r;
    fire_nxt = 1'b0;
    if (!dbn.bad) begin
      cnt_nxt = 2'h0;
    end else if (dbn.tick) begin
      if (cnt_r == 2'(TICKS - 1)) begin
        fire_nxt = 1'b1;
        cnt_nxt = 2'h0;
      end else begin
        cnt_nxt = cnt_r + 2'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 2'h0;
      fire_r <= 1'b0;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
      fire_r <= fire_nxt;
    end
  end

  assign dbn.fire = fire_r & ce;
endmodule : rsc_debounce
`default_nettype wire

// File: design/rsc_top.sv
/*
  Reset source controller: brownout qualification, threshold and watchdog code checks,
  watchdog time-out handling, cause flags, wake settle delay and an AXI4-Lite register slave.
  Assumes all inputs are synchronous to aclk and that the core applies the reset pulses.
*/
// What this block does
// - Power-on reset clears the program counter.
// - Power-on reset presets port registers to ones.
// - Brownout detection works only when option enabled.
// - Brownout fires only after low exceeds qualify time.
// - Brownout reset sets brownout cause flag bit 2.
// - Invalid threshold code resets on the 2nd tick.
// - Threshold code reset sets cause flag bit 1.
// - Threshold select powers up as 01010101.
// - Software may write any threshold byte.
// - Brownout detection disabled during power-down mode.
// - Normal watchdog time-out: full reset, expired flag.
// - Sleep time-out clears PC/SP, sets flag only.
// - Sleep time-out waits settle time before resuming.
// - Expired/power-down flags follow each reset kind; here only watchdog time-outs set them and only power-on reset clears them.
// - Bad watchdog enable code resets, sets bit 0.
`include "rsc_map.svh"
`default_nettype none
module rsc_top #(
  parameter int unsigned BO_QUALIFY_CYC = `RSC_BO_QUAL_CYC,
  parameter int unsigned SETTLE_FAST = `RSC_SETTLE_FAST_CYC,
  parameter int unsigned SETTLE_SLOW = `RSC_SETTLE_SLOW_TICKS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic brownout_option_en,
  input wire logic supply_low,
  input wire logic powerdown_mode,
  input wire logic wdog_timeout,
  input wire logic slow_osc_tick,
  input wire logic fast_osc_selected,
  input wire logic [4:0] watchdog_enable_code,
  output logic core_full_reset,
  output logic pc_sp_clear,
  output logic port_preset,
  output logic cpu_hold,
  output logic watchdog_expired_flag,
  output logic powerdown_flag,
  output logic irq
);
  localparam int unsigned BOW = $clog2(BO_QUALIFY_CYC + 2);

  function automatic logic rsc_hit(input logic [7:0] addr, input logic [7:0] off);
    rsc_hit = (addr[7:2] == off[7:2]);
  endfunction : rsc_hit

  rsc_dbn_if dbn_thr ();
  rsc_dbn_if dbn_wd ();

  logic [BOW-1:0] bo_cnt_r, bo_cnt_nxt;
  logic [7:0] thr_r, thr_nxt;
  logic [2:0] cause_r, cause_nxt;
  logic to_r, to_nxt, pdf_r, pdf_nxt;
  rsc_pkg::rsc_irq_t irq_st_r, irq_st_nxt, irq_msk_r, irq_msk_nxt;
  logic core_rst_r, core_rst_nxt, pcsp_r, pcsp_nxt, preset_r, preset_nxt;
  rsc_pkg::rsc_state_e state_r, state_nxt;
  logic [4:0] settle_r, settle_nxt, hold_len_r, hold_len_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic bo_watch, ev_bo, ev_wdt_norm, ev_wdt_sleep, full_ev;
  logic wr_go, rd_go, wr_thr, wr_sys, wr_msk, rd_irq_clr;
  rsc_pkg::rsc_irq_t ev_vec;

  // Only the low supply is watched while the option is on and the core is awake.
  assign bo_watch = brownout_option_en & ~powerdown_mode & supply_low;
  // Firing one cycle past the count makes the low state strictly longer than the limit.
  assign ev_bo = ce & bo_watch & (bo_cnt_r == BOW'(BO_QUALIFY_CYC));
  assign ev_wdt_norm = ce & wdog_timeout & ~powerdown_mode;
  assign ev_wdt_sleep = ce & wdog_timeout & powerdown_mode;
  assign full_ev = ev_bo | dbn_thr.fire | dbn_wd.fire | ev_wdt_norm;
  assign ev_vec = {wdog_timeout & ce, ev_bo, dbn_thr.fire, dbn_wd.fire};

  assign dbn_thr.bad = (thr_r != `RSC_THR_OK0) && (thr_r != `RSC_THR_OK1)
                       && (thr_r != `RSC_THR_OK2);
  assign dbn_thr.tick = slow_osc_tick;
  assign dbn_wd.bad = (watchdog_enable_code != `RSC_WE_OK0)
                      && (watchdog_enable_code != `RSC_WE_OK1);
  assign dbn_wd.tick = slow_osc_tick;

  rsc_debounce u_dbn_thr (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .dbn(dbn_thr)
  );

  rsc_debounce u_dbn_wd (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .dbn(dbn_wd)
  );

  assign wr_go = s_axi_awvalid & s_axi_wvalid & ~bvalid_r;
  assign rd_go = s_axi_arvalid & ~rvalid_r;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = rd_go;
  assign wr_thr = wr_go & s_axi_wstrb[0] & rsc_hit(s_axi_awaddr, `RSC_OFF_THRESH);
  assign wr_sys = wr_go & s_axi_wstrb[0] & rsc_hit(s_axi_awaddr, `RSC_OFF_SYSCTL);
  assign wr_msk = wr_go & s_axi_wstrb[0] & rsc_hit(s_axi_awaddr, `RSC_OFF_IRQMSK);
  assign rd_irq_clr = rd_go & rsc_hit(s_axi_araddr, `RSC_OFF_IRQST);

  always_comb begin
    bo_cnt_nxt = bo_cnt_r;
    if (!bo_watch) begin
      bo_cnt_nxt = '0;
    end else if (bo_cnt_r != BOW'(BO_QUALIFY_CYC + 1)) begin
      bo_cnt_nxt = bo_cnt_r + BOW'(1);
    end
    thr_nxt = thr_r;
    // A full reset restores the default code, otherwise a bad code would reset forever.
    if (full_ev) begin
      thr_nxt = `RSC_THR_RESET;
    end else if (wr_thr) begin
      thr_nxt = s_axi_wdata[7:0];
    end
    cause_nxt = cause_r & (wr_sys ? s_axi_wdata[2:0] : 3'h7);
    cause_nxt[`RSC_BIT_BO] = cause_nxt[`RSC_BIT_BO] | ev_bo;
    cause_nxt[`RSC_BIT_THR] = cause_nxt[`RSC_BIT_THR] | dbn_thr.fire;
    cause_nxt[`RSC_BIT_WDSW] = cause_nxt[`RSC_BIT_WDSW] | dbn_wd.fire;
    to_nxt = to_r | wdog_timeout & ce;
    pdf_nxt = pdf_r | ev_wdt_sleep;
    irq_st_nxt = (rd_irq_clr ? 4'h0 : irq_st_r) | ev_vec;
    irq_msk_nxt = wr_msk ? s_axi_wdata[3:0] : irq_msk_r;
    core_rst_nxt = full_ev;
    preset_nxt = full_ev;
    pcsp_nxt = full_ev | ev_wdt_sleep;
  end

  always_comb begin
    state_nxt = state_r;
    settle_nxt = settle_r;
    hold_len_nxt = cpu_hold ? hold_len_r + 5'h01 : 5'h00;
    case (state_r)
      rsc_pkg::RSC_ST_RUN: begin
        if (ev_wdt_sleep && !full_ev) begin
          state_nxt = rsc_pkg::RSC_ST_SETTLE;
          settle_nxt = 5'h00;
        end
      end
      rsc_pkg::RSC_ST_SETTLE: begin
        if (full_ev) begin
          state_nxt = rsc_pkg::RSC_ST_RUN;
        end else if (fast_osc_selected) begin
          if (settle_r >= 5'(SETTLE_FAST - 1)) begin
            state_nxt = rsc_pkg::RSC_ST_RUN;
          end else begin
            settle_nxt = settle_r + 5'h01;
          end
        end else if (slow_osc_tick) begin
          if (settle_r >= 5'(SETTLE_SLOW - 1)) begin
            state_nxt = rsc_pkg::RSC_ST_RUN;
          end else begin
            settle_nxt = settle_r + 5'h01;
          end
        end
      end
      default: begin
        state_nxt = rsc_pkg::RSC_ST_RUN;
      end
    endcase
  end

  always_comb begin
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (wr_go) begin
      bvalid_nxt = 1'b1;
      bresp_nxt = (rsc_hit(s_axi_awaddr, `RSC_OFF_THRESH) || rsc_hit(s_axi_awaddr, `RSC_OFF_SYSCTL)
                   || rsc_hit(s_axi_awaddr, `RSC_OFF_RSTST) || rsc_hit(s_axi_awaddr, `RSC_OFF_IRQST)
                   || rsc_hit(s_axi_awaddr, `RSC_OFF_IRQMSK)) ? 2'h0 : 2'h2;
    end
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (rd_go) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = 2'h0;
      rdata_nxt = 32'h0000_0000;
      if (rsc_hit(s_axi_araddr, `RSC_OFF_THRESH)) begin
        rdata_nxt[7:0] = thr_r;
      end else if (rsc_hit(s_axi_araddr, `RSC_OFF_SYSCTL)) begin
        rdata_nxt[2:0] = cause_r;
      end else if (rsc_hit(s_axi_araddr, `RSC_OFF_RSTST)) begin
        rdata_nxt[`RSC_BIT_TO] = to_r;
        rdata_nxt[`RSC_BIT_PDF] = pdf_r;
      end else if (rsc_hit(s_axi_araddr, `RSC_OFF_IRQST)) begin
        rdata_nxt[3:0] = irq_st_r;
      end else if (rsc_hit(s_axi_araddr, `RSC_OFF_IRQMSK)) begin
        rdata_nxt[3:0] = irq_msk_r;
      end else begin
        rresp_nxt = 2'h2;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bo_cnt_r <= '0;
      thr_r <= `RSC_THR_RESET;
      cause_r <= 3'h0;
      to_r <= 1'b0;
      pdf_r <= 1'b0;
      irq_st_r <= 4'h0;
      irq_msk_r <= 4'h0;
      core_rst_r <= 1'b1;
      preset_r <= 1'b1;
      pcsp_r <= 1'b1;
      state_r <= rsc_pkg::RSC_ST_RUN;
      settle_r <= 5'h00;
      hold_len_r <= 5'h00;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
      rvalid_r <= 1'b0;
      rresp_r <= 2'h0;
      rdata_r <= 32'h0000_0000;
    end else if (ce) begin
      bo_cnt_r <= bo_cnt_nxt;
      thr_r <= thr_nxt;
      cause_r <= cause_nxt;
      to_r <= to_nxt;
      pdf_r <= pdf_nxt;
      irq_st_r <= irq_st_nxt;
      irq_msk_r <= irq_msk_nxt;
      core_rst_r <= core_rst_nxt;
      preset_r <= preset_nxt;
      pcsp_r <= pcsp_nxt;
      state_r <= state_nxt;
      settle_r <= settle_nxt;
      hold_len_r <= hold_len_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // The bus handshakes are not gated by ce, so the bus must stay idle while ce is low.
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign core_full_reset = core_rst_r;
  assign port_preset = preset_r;
  assign pc_sp_clear = pcsp_r;
  assign cpu_hold = (state_r == rsc_pkg::RSC_ST_SETTLE);
  assign watchdog_expired_flag = to_r;
  assign powerdown_flag = pdf_r;
  assign irq = |(irq_st_r & irq_msk_r);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_por_state;
    $rose(aresetn) |-> core_full_reset && pc_sp_clear && port_preset
      && !watchdog_expired_flag && !powerdown_flag && (thr_r == `RSC_THR_RESET);
  endproperty
  a_por_state: assert property (p_por_state) else $error("power-on state wrong");

  property p_bo_off;
    (ce && (!brownout_option_en || powerdown_mode)) |=> (bo_cnt_r == '0) && !ev_bo;
  endproperty
  a_bo_off: assert property (p_bo_off) else $error("brownout active while off");

  property p_bo_flag;
    ev_bo |=> cause_r[`RSC_BIT_BO] && core_full_reset && (thr_r == `RSC_THR_RESET);
  endproperty
  a_bo_flag: assert property (p_bo_flag) else $error("brownout reset missing");

  property p_thr_flag;
    dbn_thr.fire |=> cause_r[`RSC_BIT_THR] && core_full_reset && port_preset;
  endproperty
  a_thr_flag: assert property (p_thr_flag) else $error("threshold reset missing");

  property p_wd_code;
    dbn_wd.fire |=> cause_r[`RSC_BIT_WDSW] && core_full_reset;
  endproperty
  a_wd_code: assert property (p_wd_code) else $error("watchdog code reset missing");

  property p_wdt_norm;
    ev_wdt_norm |=> core_full_reset && watchdog_expired_flag && ($stable(powerdown_flag));
  endproperty
  a_wdt_norm: assert property (p_wdt_norm) else $error("normal time-out wrong");

  property p_wdt_sleep;
    (ev_wdt_sleep && !full_ev) |=> pc_sp_clear && !core_full_reset && cpu_hold
      && watchdog_expired_flag && powerdown_flag;
  endproperty
  a_wdt_sleep: assert property (p_wdt_sleep) else $error("sleep time-out wrong");

  property p_settle_fast;
    (ce && cpu_hold && fast_osc_selected && (hold_len_r == 5'(SETTLE_FAST - 1))) |=> !cpu_hold;
  endproperty
  a_settle_fast: assert property (p_settle_fast) else $error("settle time wrong");

  property p_sticky;
    (ce && cause_r[`RSC_BIT_WDSW] && !wr_sys) |=> cause_r[`RSC_BIT_WDSW];
  endproperty
  a_sticky: assert property (p_sticky) else $error("cause flag lost");

  property p_thr_write;
    (ce && wr_thr && !full_ev) |=> (thr_r == $past(s_axi_wdata[7:0]));
  endproperty
  a_thr_write: assert property (p_thr_write) else $error("threshold write lost");
endmodule : rsc_top
`default_nettype wire

// File: bench/rsc_core_model.sv
/*
  Stand-in for the CPU core: program counter, stack pointer and one port register.
  Assumes the reset pulses and the hold level come from the controller on aclk.
*/
`default_nettype none
module rsc_core_model (
  input wire logic aclk,
  input wire logic core_full_reset,
  input wire logic pc_sp_clear,
  input wire logic port_preset,
  input wire logic cpu_hold,
  output logic [7:0] pc,
  output logic [7:0] sp,
  output logic [7:0] port_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // The program moves the stack and drives the port low early on, so each preset shows.
  always_ff @(posedge aclk) begin
    if (pc_sp_clear || core_full_reset) begin
      pc <= 8'h00;
      sp <= 8'h00;
    end else if (!cpu_hold) begin
      pc <= pc + 8'h01;
      sp <= (pc == 8'h02) ? 8'h05 : sp;
    end
    if (port_preset) begin
      port_data <= 8'hFF;
    end else if (pc == 8'h03) begin
      port_data <= 8'h00;
    end
  end
endmodule : rsc_core_model
`default_nettype wire

// File: bench/reset_source_controller_test.sv
/*
  Self-checking bench of the reset source controller over AXI4-Lite and its event inputs.
  Assumes the design files and the core stand-in are compiled first.
*/
`default_nettype none
module reset_source_controller_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic bvalid, arready, rvalid, bo_en, low, pd_mode, wdog, tick_p, fast, full, pcsp, pre;
  logic hold, exp_f, pd_f, irq, full_d, hold_d;
  logic [7:0] awaddr, araddr, pc, sp, port_data, thr_c[3];
  logic [4:0] en_code;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] wdata, rdata, rv;
  int err_total, n_tests, cyc, n_full, n_sleep, n_hold, nf, ns;

  rsc_top #(.BO_QUALIFY_CYC(8)) rsc_top_i (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .brownout_option_en(bo_en), .supply_low(low), .powerdown_mode(pd_mode),
    .wdog_timeout(wdog), .slow_osc_tick(tick_p), .fast_osc_selected(fast),
    .watchdog_enable_code(en_code), .core_full_reset(full), .pc_sp_clear(pcsp),
    .port_preset(pre), .cpu_hold(hold), .watchdog_expired_flag(exp_f),
    .powerdown_flag(pd_f), .irq(irq));
  rsc_core_model rsc_core_model_i (.aclk(aclk), .core_full_reset(full), .pc_sp_clear(pcsp),
    .port_preset(pre), .cpu_hold(hold), .pc(pc), .sp(sp), .port_data(port_data));

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic wrap_up();
    if (err_total == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic w(input int n);
    repeat (n) @(posedge aclk);
  endtask : w

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge aclk); while (!(awready && wready));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge aclk); while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
    w(1);
  endtask : wr

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rv = rdata;
    resp = rresp;
    rready <= 1'b0;
    w(1);
    chk(nm, rv, exp);
  endtask : rchk

  task automatic tick(input int n);
    repeat (n) begin
      tick_p <= 1'b1;
      w(1);
      tick_p <= 1'b0;
      w(3);
    end
  endtask : tick

  task automatic lowfor(input int n);
    low <= 1'b1;
    w(n);
    low <= 1'b0;
    w(6);
  endtask : lowfor

  task automatic bark();
    wdog <= 1'b1;
    w(1);
    wdog <= 1'b0;
  endtask : bark

  // Every full reset and every wake must leave the core at its documented start point.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    full_d <= full;
    hold_d <= hold;
    if (full === 1'b1 && full_d === 1'b0) n_full <= n_full + 1;
    if (pcsp === 1'b1 && full === 1'b0) n_sleep <= n_sleep + 1;
    if (hold === 1'b1) n_hold <= n_hold + 1;
    if (full_d === 1'b1 && full === 1'b0) begin
      chk("pc_after_reset", {24'h0, pc}, 32'h0);
      chk("port_after_reset", {24'h0, port_data}, 32'hFF);
    end
    if (hold_d === 1'b1 && hold === 1'b0) begin
      chk("pc_sp_after_wake", {16'h0, sp, pc}, 32'h0);
      chk("port_after_wake", {24'h0, port_data}, 32'h0);
    end
    if (cyc > 5000) begin
      err_total++;
      wrap_up();
    end
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, bo_en, low, pd_mode} = 9'h000;
    {wdog, tick_p, awaddr, araddr, wdata} = 50'h0;
    {ce, fast, wstrb, en_code} = {2'b11, 4'hF, 5'h15};
    thr_c = '{8'h33, 8'hAA, 8'h55};
    w(6);
    aresetn <= 1'b1;
    w(4);
    rchk("thr_reset", 8'h00, 32'h55);
    rchk("cause_reset", 8'h04, 32'h0);
    rchk("to_pdf_reset", 8'h08, 32'h0);
    rchk("unmapped", 8'h20, 32'h0);
    chk("unmapped_resp", resp, 2'b10);
    wr(8'h20, 8'h00);
    chk("wr_unmapped_resp", resp, 2'b10);
    nf = n_full;
    wr(8'h00, 8'h12);
    tick(1);
    chk("thr_one_tick", n_full - nf, 0);
    tick(1);
    w(4);
    chk("thr_reset_count", n_full - nf, 1);
    rchk("cause_thr", 8'h04, 32'h2);
    rchk("thr_restored", 8'h00, 32'h55);
    chk("irq_masked", irq, 1'b0);
    wr(8'h10, 8'h02);
    chk("irq_on", irq, 1'b1);
    chk("wr_resp", resp, 2'b00);
    rchk("irq_mask", 8'h10, 32'h2);
    rchk("irq_status", 8'h0C, 32'h2);
    chk("irq_cleared", irq, 1'b0);
    for (int i = 0; i < 3; i++) begin
      en_code <= i[0] ? 5'h15 : 5'h0A;
      wr(8'h00, thr_c[i]);
      tick(3);
      chk("valid_codes", n_full - nf, 1);
    end
    nf = n_full;
    lowfor(20);
    chk("bo_option_off", n_full - nf, 0);
    bo_en <= 1'b1;
    lowfor(8);
    chk("bo_short", n_full - nf, 0);
    pd_mode <= 1'b1;
    lowfor(20);
    pd_mode <= 1'b0;
    chk("bo_powerdown", n_full - nf, 0);
    lowfor(12);
    chk("bo_long", n_full - nf, 1);
    rchk("cause_bo", 8'h04, 32'h6);
    bark();
    w(6);
    chk("wdt_normal", n_full - nf, 2);
    chk("to_pdf_normal", {exp_f, pd_f}, 2'b10);
    rchk("status_normal", 8'h08, 32'h1);
    en_code <= 5'h00;
    tick(2);
    en_code <= 5'h15;
    w(4);
    chk("wdcode_reset", n_full - nf, 3);
    ce <= 1'b0;
    bark();
    w(2);
    ce <= 1'b1;
    w(4);
    chk("ce_frozen", n_full - nf, 3);
    rchk("cause_all", 8'h04, 32'h7);
    pd_mode <= 1'b1;
    ns = n_sleep;
    n_hold = 0;
    bark();
    w(24);
    chk("sleep_no_full", n_full - nf, 3);
    chk("sleep_pcsp", n_sleep - ns, 1);
    chk("settle_fast", n_hold, 16);
    chk("to_pdf_sleep", {exp_f, pd_f}, 2'b11);
    fast <= 1'b0;
    n_hold = 0;
    bark();
    tick(3);
    chk("settle_slow", n_hold >= 4 && n_hold <= 10, 1'b1);
    pd_mode <= 1'b0;
    wr(8'h04, 8'h00);
    rchk("cause_cleared", 8'h04, 32'h0);
    wrap_up();
  end
endmodule : reset_source_controller_test
`default_nettype wire
